// file: verilog/sdram_core.sv
/*
  Command decoder, bank state, burst engine, clock-enable power modes and
  data pins of a four-bank 16-bit synchronous DRAM.
  Assumes the controller keeps its own timing and command order; all pins
  are synchronous to clk. Read latency is fixed at two clocks, whatever
  the programmed latency field holds.
*/
`timescale 1ns/100ps
module sdram_core
  import sdram_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BANK_W-1:0] bank_select,
  input  wire logic [ADDR_W-1:0] addr_bus,
  input  wire logic              low_byte_mask,
  input  wire logic              high_byte_mask,
  input  wire logic [DATA_W-1:0] data_bus_lines_in,
  output logic      [DATA_W-1:0] data_bus_lines_out,
  output logic      [1:0]        data_bus_lines_oe,
  output logic      [BANKS-1:0]  bank_active,
  output logic      [BANKS-1:0]  bank_precharging,
  output logic      [5:0]        power_mode,
  output logic                   burst_busy
);
  // Whole control state of the device
  typedef struct packed {
    power_type                     pwr;       // Power mode
    logic [ADDR_W-1:0]             mode;      // Mode register
    logic [ADDR_W-1:0]             ext_mode;  // Extended mode register
    logic [BANKS-1:0]              open;      // Row open per bank
    logic [BANKS-1:0][ROW_W-1:0]   row;       // Open row per bank
    logic [BANKS-1:0]              pre;       // Precharge running
    logic [BANKS-1:0][TMR_W-1:0]   tmr;       // Precharge countdown
    logic                          burst;     // Burst owns the pins
    logic                          wr;        // Burst is a write
    logic                          ap;        // Auto precharge after it
    logic [BANK_W-1:0]             bank;      // Bank of the burst
    logic                          v1;        // Read word in stage one
    logic [1:0]                    m1;        // Mask sampled with it
    logic [DATA_W-1:0]             d1;        // Word in stage one
    logic [DATA_W-1:0]             dout;      // Output register
    logic [1:0]                    oe;        // Byte lane drivers
  } core_state_type;

  // Run mode, burst length one, every bank idle
  localparam core_state_type CORE_RESET = '{pwr: ST_RUN, mode: MODE_RESET,
                                            default: '0};

  core_state_type s_q;  // Registered state
  core_state_type s_d;  // Next state

  // Array contents; too large to sit inside the state struct
  logic [DATA_W-1:0] mem [0:(1 << MEM_W) - 1];

  burst_if bc ();  // Link to the column counter

  // Decode and access path
  logic [2:0]        cmd;       // Strobe code
  logic              adv;       // Internal clock ticks this cycle
  logic              decode;    // Command decoder enabled
  logic              take;      // Read or write accepted
  logic              is_wr;     // Accepted command is a write
  logic              beat_go;   // A column is accessed this cycle
  logic              beat_wr;   // That access writes
  logic [BANK_W-1:0] beat_bank; // Bank of the access
  logic [COL_W-1:0]  beat_col;  // Column of the access
  logic [MEM_W-1:0]  beat_idx;  // Flat array index
  logic [DATA_W-1:0] mem_rd;    // Array read word
  logic              hold;      // Freeze burst and read pipeline
  logic [LEN_W-1:0]  bl_len;    // Programmed burst length
  logic [1:0]        mask;      // {high, low} byte masks

  // Strobes sampled with chip select form the command
  assign cmd    = {ras_n, cas_n, we_n};
  assign mask   = {high_byte_mask, low_byte_mask};
  // Clock enable gates decode, bursts and reads; precharge timers run on
  assign adv    = (s_q.pwr == ST_RUN) && cke;
  // Select high masks everything; power-down leaves the decoder off
  assign decode = adv && !cs_n;
  assign is_wr  = (cmd == CMD_WR);
  // A column command needs its bank opened first
  assign take   = decode && ((cmd == CMD_RD) || is_wr) &&
                  s_q.open[bank_select];
  // Suspend stalls only a burst in flight
  assign hold   = !adv && s_q.burst;

  // Burst length from the mode register; single write mode forces one
  // Follows the register live: a load in mid-burst rewraps it
  always_comb begin
    case (s_q.mode[BL_MSB:BL_LSB])
      BL_2:    bl_len = LEN_2;
      BL_4:    bl_len = LEN_4;
      BL_8:    bl_len = LEN_8;
      BL_PAGE: bl_len = LEN_PAGE;
      default: bl_len = LEN_1;
    endcase
    if (is_wr && s_q.mode[WB_BIT]) begin
      bl_len = LEN_1;
    end
  end

  // Drive the counter: a new command restarts it at once
  // Terminate beats a same-cycle load inside the counter
  assign bc.load      = take;
  assign bc.step      = adv && s_q.burst && !take;
  assign bc.clear     = decode && (cmd == CMD_BST);
  assign bc.fp        = (bl_len == LEN_PAGE);
  assign bc.len       = bl_len;
  assign bc.wrap_mask = COL_W'(bl_len - LEN_1);
  assign bc.start_col = addr_bus[COL_W-1:0];

  // Column generator on the core clock and reset
  burst_counter u_counter (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bus     (bc)
  );

  // Column of this cycle: the command's own, else the generated one
  // The terminate cycle carries no data, so its word is dropped
  assign beat_go   = take ||
                     (adv && s_q.burst && bc.active && !bc.clear);
  assign beat_col  = take ? addr_bus[COL_W-1:0] : bc.col;
  assign beat_bank = take ? bank_select : s_q.bank;
  assign beat_wr   = take ? is_wr : s_q.wr;
  assign beat_idx  = {beat_bank, s_q.row[beat_bank], beat_col};
  assign mem_rd    = mem[beat_idx];

  // Array writes; a masked lane keeps its old contents
  // Lanes are written apart so each mask acts alone
  always_ff @(posedge clk) begin
    if (beat_go && beat_wr && !low_byte_mask) begin
      mem[beat_idx][7:0] <= data_bus_lines_in[7:0];
    end
    if (beat_go && beat_wr && !high_byte_mask) begin
      mem[beat_idx][15:8] <= data_bus_lines_in[15:8];
    end
  end

  // Next-state logic for banks, burst, power mode and read pipeline
  always_comb begin
    s_d = s_q;
    // Independent precharge timers let banks overlap
    for (int b = 0; b < BANKS; b++) begin
      if (s_q.pre[b]) begin
        s_d.tmr[b] = s_q.tmr[b] - TMR_ONE;
        if (s_q.tmr[b] == TMR_ONE) begin
          s_d.pre[b] = 1'b0;
        end
      end
    end
    // An auto precharge burst that ends or is cut off by a new read or write closes its row
    if (adv && s_q.burst && s_q.ap && (take || !bc.active)) begin
      s_d.open[s_q.bank] = 1'b0;
      s_d.pre[s_q.bank]  = 1'b1;
      s_d.tmr[s_q.bank]  = PRE_CYC;
    end
    if (adv && s_q.burst && !bc.active) begin
      s_d.burst = 1'b0;
    end
    if (decode) begin
      case (cmd)
        CMD_ACT: begin
          // Refuse a bank that is open or still precharging
          if (!s_q.open[bank_select] && !s_q.pre[bank_select]) begin
            s_d.open[bank_select] = 1'b1;
            s_d.row[bank_select]  = addr_bus[ROW_W-1:0];
          end
        end
        CMD_RD, CMD_WR: begin
          if (take) begin
            s_d.burst = 1'b1;
            s_d.wr    = is_wr;
            s_d.ap    = addr_bus[AP_BIT];
            s_d.bank  = bank_select;
          end
        end
        CMD_BST: begin
          s_d.burst = 1'b0;
        end
        CMD_PRE: begin
          for (int b = 0; b < BANKS; b++) begin
            if ((addr_bus[AP_BIT] || BANK_W'(b) == bank_select) &&
                s_q.open[b]) begin
              s_d.open[b] = 1'b0;
              s_d.pre[b]  = 1'b1;
              s_d.tmr[b]  = PRE_CYC;
            end
          end
        end
        CMD_LMR: begin
          if (bank_select == SEL_MODE) begin
            s_d.mode = addr_bus;
          end else if (bank_select == SEL_EXT) begin
            s_d.ext_mode = addr_bus;
          end
        end
        default: begin
          // No-op and refresh leave the pins alone
        end
      endcase
    end
    // Clock enable low picks the mode from what is in progress
    // A suspended burst keeps its columns and read pipeline
    case (s_q.pwr)
      ST_RUN: begin
        if (!cke) begin
          if (s_q.burst && bc.active) begin
            s_d.pwr = ST_SUSPEND;
          end else if (s_q.open != '0) begin
            s_d.pwr = ST_PD_ACT;
          end else if (!cs_n && cmd == CMD_AREF) begin
            s_d.pwr = ST_SELF;
          end else if (!cs_n && cmd == CMD_BST) begin
            s_d.pwr = ST_DEEP;
          end else begin
            s_d.pwr = ST_PD_PRE;
          end
        end
      end
      default: begin
        // Only clock enable is watched until the mode is left
        if (cke) begin
          s_d.pwr = ST_RUN;
        end
      end
    endcase
    // Two-stage read path; the mask rides along with its cycle
    if (!hold) begin
      s_d.v1   = beat_go && !beat_wr;
      s_d.m1   = mask;
      s_d.d1   = mem_rd;
      s_d.dout = s_q.d1;
      s_d.oe   = {2{s_q.v1}} & ~s_q.m1;
    end
  end

  // One register for all control state
  // Array contents survive reset; only control state clears
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= CORE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Pins and status straight from the state register
  assign data_bus_lines_out = s_q.dout;
  assign data_bus_lines_oe  = s_q.oe;
  assign bank_active        = s_q.open;
  assign bank_precharging   = s_q.pre;
  assign power_mode         = s_q.pwr;
  assign burst_busy         = s_q.burst;

  // Checks below share the core clock and reset
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Read with both lanes enabled, clock running two more cycles
  sequence s_read_open;
    take && !is_wr && mask == 2'b00;
  endsequence
  // Same read with the low lane masked
  sequence s_read_low_masked;
    take && !is_wr && mask == 2'b01;
  endsequence
  sequence s_clock_runs;
    cke [*2];
  endsequence

  a_read_drives: assert property (
    s_read_open ##1 s_clock_runs |-> data_bus_lines_oe == 2'b11)
    else $error("read data not driven two clocks after command");

  a_mask_floats: assert property (
    s_read_low_masked ##1 s_clock_runs |-> data_bus_lines_oe == 2'b10)
    else $error("low mask did not float low lane");

  // Open latches bank and row
  a_row_opens: assert property (
    (decode && cmd == CMD_ACT && !s_q.open[bank_select] &&
     !s_q.pre[bank_select])
    |=> bank_active[$past(bank_select)] &&
        s_q.row[$past(bank_select)] == $past(addr_bus[ROW_W-1:0]))
    else $error("row open did not latch bank and row");

  // Masked decoder opens no row
  a_select_masks: assert property (
    (cs_n || !cke) |=> (bank_active & ~$past(bank_active)) == '0)
    else $error("bank opened with decoder masked");

  // Precharge all closes and times out
  a_precharge_all: assert property (
    (decode && cmd == CMD_PRE && addr_bus[AP_BIT])
    |=> bank_active == '0 ##[1:8] bank_precharging == '0)
    else $error("precharge all left a bank busy");

  // Suspend freezes the lane drivers
  a_suspend_entry: assert property (
    (s_q.pwr == ST_RUN && !cke && s_q.burst && bc.active)
    |=> power_mode == ST_SUSPEND && $stable(data_bus_lines_oe))
    else $error("clock enable low in burst did not suspend");

  a_pd_active: assert property (
    (s_q.pwr == ST_RUN && !cke && !(s_q.burst && bc.active) &&
     s_q.open != '0) |=> power_mode == ST_PD_ACT)
    else $error("open row did not give active power-down");

  // Self-timed precharge follows the last column
  a_auto_pre: assert property (
    (adv && s_q.burst && s_q.ap && !bc.active)
    |=> !bank_active[$past(s_q.bank)] && bank_precharging[$past(s_q.bank)])
    else $error("auto precharge did not start after burst");

  // Open rows and power mode hold while the clock is stopped
  a_pd_ignores: assert property (
    (s_q.pwr != ST_RUN && !cke)
    |=> $stable(bank_active) && $stable(power_mode))
    else $error("bank state changed while powered down");

  // Extended load spares the mode register
  a_mode_load: assert property (
    (decode && cmd == CMD_LMR && bank_select == SEL_EXT)
    |=> s_q.ext_mode == $past(addr_bus) && $stable(s_q.mode))
    else $error("extended mode load went to wrong register");

  // Terminate drops its own cycle and frees the pins
  a_burst_stops: assert property (
    (decode && cmd == CMD_BST) |-> !beat_go ##1 !burst_busy)
    else $error("terminate left the burst running");

  // Clock enable high always leaves a low-power mode
  a_power_exit: assert property (
    (s_q.pwr != ST_RUN && cke) |=> power_mode == ST_RUN)
    else $error("clock enable high did not end power-down");
endmodule

// file: verilog/sdram_pkg.sv
/*
  Constants, command codes, mode fields and the power-state type for the
  synchronous DRAM pin interface model.
  Assumes a single 20 MHz clock and commands coded on {ras, cas, we}.
*/
// Behaviour
// - All pins sampled on rising clock edge
// - Row open uses bank select and row
// - Four banks of 4096x512 sixteen-bit words
// - Start column registered, later columns generated
// - Burst 1, 2, 4, 8, page; terminable
// - Auto precharge starts after burst ends
// - New column accepted every clock
// - Banks precharge while another is accessed
// - Clock enable high runs, low stops
// - Clock enable low picks power mode
// - Power-down ignores inputs until exit
// - Chip select high masks every command
// - Command decoded from select and strobes
// - Write mask high drops that byte
// - Read mask high floats byte two clocks later
// - Low mask bits 0-7, high 8-15
// - Precharge bit 10 selects all banks
// - Bank select picks mode or extended register
// - Read or write column from bits 0-8
package sdram_pkg;
  localparam int BANK_W = 2;           // Bank select width
  localparam int BANKS  = 4;           // Banks in the array
  localparam int ROW_W  = 12;          // 4096 rows per bank
  localparam int COL_W  = 9;           // 512 columns per row
  localparam int DATA_W = 16;          // Word width
  localparam int ADDR_W = 12;          // Address pins
  localparam int LEN_W  = 10;          // Burst length count
  localparam int MEM_W  = BANK_W + ROW_W + COL_W;
  localparam int AP_BIT = 10;          // Auto precharge / all banks bit
  localparam int WB_BIT = 9;           // Single write burst mode bit
  localparam int BL_LSB = 0;           // Burst length field
  localparam int BL_MSB = 2;
  // Command codes on {ras, cas, we}
  localparam logic [2:0] CMD_LMR  = 3'h0;
  localparam logic [2:0] CMD_AREF = 3'h1;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_BST  = 3'h6;
  // Mode register selection on bank select
  localparam logic [1:0] SEL_MODE = 2'h0;
  localparam logic [1:0] SEL_EXT  = 2'h2;
  // Burst length codes
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [LEN_W-1:0] LEN_1    = 10'h001;
  localparam logic [LEN_W-1:0] LEN_2    = 10'h002;
  localparam logic [LEN_W-1:0] LEN_4    = 10'h004;
  localparam logic [LEN_W-1:0] LEN_8    = 10'h008;
  localparam logic [LEN_W-1:0] LEN_PAGE = 10'h200;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  // Self-timed precharge duration
  localparam int CLK_MHZ      = 20;
  localparam int PRECHARGE_NS = 20;
  localparam int PRE_CYC_RAW  = (PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W        = 4;
  localparam logic [TMR_W-1:0] PRE_CYC =
    TMR_W'((PRE_CYC_RAW < 1) ? 1 : PRE_CYC_RAW);
  localparam logic [TMR_W-1:0] TMR_ONE = 4'h1;
  // Power states, one-hot
  typedef enum logic [5:0] {
    ST_RUN     = 6'h01,
    ST_SUSPEND = 6'h02,
    ST_PD_PRE  = 6'h04,
    ST_PD_ACT  = 6'h08,
    ST_SELF    = 6'h10,
    ST_DEEP    = 6'h20
  } power_type;
endpackage

// file: verilog/burst_if.sv
/*
  Carrier between the command core and its column burst counter.
  Assumes both ends share clk and sys_rst.
*/
`timescale 1ns/100ps
interface burst_if;
  import sdram_pkg::*;
  logic             load;       // Start a burst
  logic             step;       // Advance one column
  logic             clear;      // Terminate the burst
  logic             fp;         // Full page, never runs out
  logic [COL_W-1:0] start_col;  // First column of burst
  logic [COL_W-1:0] wrap_mask;  // Burst length minus one
  logic [LEN_W-1:0] len;        // Burst length in words
  logic [COL_W-1:0] col;        // Next column to use
  logic             active;     // Columns still owed
  modport core    (output load, step, clear, fp, start_col, wrap_mask,
                   len, input col, active);
  modport counter (input load, step, clear, fp, start_col, wrap_mask,
                   len, output col, active);
endinterface

// file: verilog/burst_counter.sv
/*
  Column address generator for read and write bursts.
  Assumes the core asserts step only while the device clock is enabled.
*/
`timescale 1ns/100ps
module burst_counter
  import sdram_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  burst_if.counter bus
);
  typedef struct packed {
    logic [COL_W-1:0] col;  // Next column
    logic [LEN_W-1:0] rem;  // Words still owed
    logic             fp;   // Full page burst
  } ctr_state_type;

  ctr_state_type s_q;
  ctr_state_type s_d;

  // Wrap inside the burst-length boundary
  function automatic logic [COL_W-1:0] wrap_next(
    input logic [COL_W-1:0] c, input logic [COL_W-1:0] m);
    logic [COL_W-1:0] inc;
    inc = c + 9'h001;
    return (c & ~m) | (inc & m);
  endfunction

  // Next state: terminate beats load, load beats step
  always_comb begin
    s_d = s_q;
    if (bus.clear) begin
      s_d.rem = '0;
    end else if (bus.load) begin
      s_d.col = wrap_next(bus.start_col, bus.wrap_mask);
      s_d.rem = bus.len - LEN_1;
      s_d.fp  = bus.fp;
    end else if (bus.step && (s_q.rem != '0)) begin
      s_d.col = wrap_next(s_q.col, bus.wrap_mask);
      if (!s_q.fp) begin
        s_d.rem = s_q.rem - LEN_1;  // Page bursts run until terminated
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.col    = s_q.col;
  assign bus.active = (s_q.rem != '0);

  a_burst_ends: assert property (@(posedge clk) disable iff (sys_rst)
    (bus.step && !bus.load && !bus.clear && !s_q.fp && s_q.rem == LEN_1)
    |=> !bus.active)
    else $error("burst did not end after its last column");
endmodule

// file: tb/ctrl_model.sv
/*
  Behavioural memory controller that drives every command and data pin.
  Assumes the bench calls issue once per clock; pins change on falling edges.
*/
`timescale 1ns/100ps
module ctrl_model
  import sdram_pkg::*;
(
  input  wire logic              clk,
  output logic                   cke,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic      [BANK_W-1:0] bank_select,
  output logic      [ADDR_W-1:0] addr_bus,
  output logic      [1:0]        byte_mask,
  output logic      [DATA_W-1:0] wdata
);
  logic [DATA_W-1:0] last_q;  // Last value put on the data lines

  // Idle pins: deselected, clock enabled
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    bank_select = '0;
    addr_bus = '0;
    byte_mask = '0;
    wdata = '0;
    last_q = '0;
  end

  // One command per clock, launched at the falling edge, held a full cycle
  task automatic issue(input logic sel_n, input logic [2:0] code,
      input logic [BANK_W-1:0] b, input logic [ADDR_W-1:0] a,
      input logic [1:0] m, input logic [DATA_W-1:0] d, input logic wd,
      input logic ce);
    @(negedge clk);
    cke <= ce;
    cs_n <= sel_n;
    {ras_n, cas_n, we_n} <= code;
    bank_select <= b;
    addr_bus <= a;
    byte_mask <= m;
    // Released data lines toggle so a stale word never looks valid
    last_q = wd ? d : ~last_q;
    wdata <= last_q;
  endtask
endmodule

// file: tb/tb_top.sv
/*
  Self-checking bench for the DRAM pin interface core.
  Assumes read data leaves the core two cycles after its command edge.
*/
`timescale 1ns/100ps
module tb_top;
  import sdram_pkg::*;
  typedef struct packed {
    logic [1:0]        oe;
    logic [DATA_W-1:0] d;
  } note_type;
  logic              clk;
  logic              sys_rst;
  logic              cke, cs_n, ras_n, cas_n, we_n;
  logic [BANK_W-1:0] bank_select;
  logic [ADDR_W-1:0] addr_bus;
  logic [1:0]        byte_mask, oe, seen;
  logic [DATA_W-1:0] wdata, rdata;
  logic [BANKS-1:0]  bank_active, bank_precharging;
  logic [5:0]        power_mode;
  logic              burst_busy;
  note_type          notes[$];              // Expected read words, in order
  note_type          nt;                    // Word being compared
  logic [DATA_W-1:0] shadow[logic [10:0]];  // Written words by bank, column
  logic [LEN_W-1:0]  blen;                  // Burst length now programmed
  logic [COL_W-1:0]  col;
  logic [2:0]        pwr_cmd[3];
  power_type         pwr_exp[3];
  int                failures, n_compared, seed, i, k;

  ctrl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
    .addr_bus(addr_bus), .byte_mask(byte_mask), .wdata(wdata));

  sdram_core uut (.clk(clk), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
    .addr_bus(addr_bus), .low_byte_mask(byte_mask[0]),
    .high_byte_mask(byte_mask[1]), .data_bus_lines_in(wdata),
    .data_bus_lines_out(rdata), .data_bus_lines_oe(oe),
    .bank_active(bank_active), .bank_precharging(bank_precharging),
    .power_mode(power_mode), .burst_busy(burst_busy));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic compare(input logic [DATA_W-1:0] got,
      input logic [DATA_W-1:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: %s", $time, what);
      failures++;
    end
  endtask

  task automatic wrap_up;
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic op(input logic [2:0] c, input logic [BANK_W-1:0] b,
      input logic [ADDR_W-1:0] a);
    ctl.issue(1'b0, c, b, a, 2'h0, 16'h0000, 1'b0, 1'b1);
  endtask

  task automatic nop(input int n);
    repeat (n) ctl.issue(1'b1, 3'h7, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0,
      1'b1);
  endtask

  // Sequential order wraps inside the burst-length boundary
  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] c,
      input int n);
    logic [COL_W-1:0] wm;
    wm = COL_W'(blen - 1);
    return (c & ~wm) | (COL_W'(c + n) & wm);
  endfunction

  task automatic set_bl(input logic [2:0] code, input logic [LEN_W-1:0] n);
    op(CMD_LMR, SEL_MODE, {9'h000, code});
    blen = n;
    nop(1);
  endtask

  // Write n words; masked lanes keep their old contents in the shadow
  task automatic wr(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] c,
      input int n, input logic rmask);
    logic [1:0]        m;
    logic [DATA_W-1:0] d, old;
    logic [10:0]       key;
    for (int j = 0; j < n; j++) begin
      m = rmask ? 2'($random(seed)) : 2'h0;
      d = 16'($random(seed));
      key = {b, col_at(c, j)};
      old = shadow.exists(key) ? shadow[key] : 'x;
      shadow[key] = {m[1] ? old[15:8] : d[15:8],
                     m[0] ? old[7:0] : d[7:0]};
      ctl.issue(1'b0, j == 0 ? CMD_WR : 3'h7, b, {3'h0, c}, m, d, 1'b1,
        1'b1);
    end
  endtask

  // Read a whole burst; never both lanes masked so each word shows
  task automatic rd(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] c,
      input logic ap);
    logic [1:0] m;
    for (int j = 0; j < int'(blen); j++) begin
      m = 2'({$random(seed)} % 3);
      notes.push_back({~m, shadow[{b, col_at(c, j)}]});
      ctl.issue(1'b0, j == 0 ? CMD_RD : 3'h7, b, {1'b0, ap, 1'b0, c}, m,
        16'h0000, 1'b0, 1'b1);
    end
  endtask

  // Output watcher: every driven word meets the oldest note
  initial begin
    forever begin
      @(posedge clk);
      #1;
      if (sys_rst === 1'b0 && oe !== 2'h0) begin
        if (notes.size() == 0) begin
          compare(16'h0000, 16'hFFFF, "read word with nothing expected");
        end else begin
          nt = notes.pop_front();
          compare({14'h0000, oe}, {14'h0000, nt.oe}, "lane enables");
          compare(rdata & {{8{nt.oe[1]}}, {8{nt.oe[0]}}},
            nt.d & {{8{nt.oe[1]}}, {8{nt.oe[0]}}}, "read word");
        end
      end
    end
  end

  // Guard against a hang
  initial begin
    #5000000;
    failures++;
    wrap_up();
  end

  initial begin
    seed = 42945;
    failures = 0;
    n_compared = 0;
    blen = LEN_1;
    pwr_cmd = '{3'h7, CMD_AREF, CMD_BST};
    pwr_exp = '{ST_PD_PRE, ST_SELF, ST_DEEP};
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    // Clock enable low with all banks idle picks the mode from the command
    for (k = 0; k < 3; k++) begin
      ctl.issue(1'b0, pwr_cmd[k], 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b0);
      ctl.issue(1'b1, 3'h7, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b0);
      compare({10'h000, power_mode}, {10'h000, pwr_exp[k]}, "idle pd");
      nop(2);
      compare({10'h000, power_mode}, {10'h000, ST_RUN}, "wake");
    end
    // A deselected row open must be ignored
    ctl.issue(1'b1, CMD_ACT, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0, 1'b1);
    nop(1);
    compare({12'h000, bank_active}, 16'h0000, "masked open");
    op(CMD_ACT, 2'h0, 12'h5A3);
    op(CMD_ACT, 2'h1, 12'h0C1);
    nop(1);
    compare({12'h000, bank_active}, 16'h0003, "rows open");
    repeat (2) ctl.issue(1'b1, 3'h7, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0,
      1'b0);
    compare({10'h000, power_mode}, {10'h000, ST_PD_ACT}, "active pd");
    nop(2);
    // Burst lengths 1, 2, 4 and 8, masked writes and back-to-back reads
    for (k = 0; k < 4; k++) begin
      set_bl(3'(k), LEN_W'(1 << k));
      col = 9'($random(seed));
      wr({1'b0, k[0]}, col, 1 << k, 1'b0);
      wr({1'b0, k[0]}, col, 1 << k, 1'b1);
      rd({1'b0, k[0]}, col, 1'b0);
      rd({1'b0, k[0]}, col, 1'b0);
      nop(3);
    end
    // Full page wraps past the last column and stops on terminate
    set_bl(3'h0, LEN_1);
    wr(2'h0, 9'h001, 1, 1'b0);
    set_bl(BL_PAGE, LEN_PAGE);
    wr(2'h0, 9'h1FF, 2, 1'b0);
    ctl.issue(1'b0, CMD_BST, 2'h0, 12'h000, 2'h0, 16'h1234, 1'b1, 1'b1);
    nop(1);
    compare({15'h0000, burst_busy}, 16'h0000, "terminate");
    set_bl(3'h0, LEN_1);
    rd(2'h0, 9'h1FF, 1'b0);
    rd(2'h0, 9'h000, 1'b0);
    rd(2'h0, 9'h001, 1'b0);
    nop(3);
    // Bank 0 precharges while bank 1 bursts, then auto precharge
    set_bl(BL_2, LEN_2);
    op(CMD_LMR, SEL_EXT, 12'h0A5);
    wr(2'h1, 9'h010, 2, 1'b0);
    // Single-location writes: the word after the column must survive
    op(CMD_LMR, SEL_MODE, 12'h201);
    blen = LEN_1;
    wr(2'h1, 9'h010, 1, 1'b0);
    nop(1);
    blen = LEN_2;
    notes.push_back({2'h3, shadow[{2'h1, 9'h010}]});
    notes.push_back({2'h3, shadow[{2'h1, 9'h011}]});
    op(CMD_RD, 2'h1, 12'h010);
    op(CMD_PRE, 2'h0, 12'h000);
    seen = 2'h0;
    for (i = 0; i < 4; i++) begin
      nop(1);
      seen = seen | bank_precharging[1:0];
    end
    compare({12'h000, bank_active}, 16'h0002, "single bank");
    rd(2'h1, 9'h010, 1'b1);
    for (i = 0; i < 6; i++) begin
      nop(1);
      seen = seen | bank_precharging[1:0];
    end
    compare({12'h000, bank_active}, 16'h0000, "auto close");
    compare({14'h0000, seen}, 16'h0003, "precharge timers");
    // Suspend in mid-burst, then precharge every bank at once
    op(CMD_ACT, 2'h2, 12'h010);
    op(CMD_ACT, 2'h3, 12'h020);
    set_bl(BL_8, LEN_8);
    compare({12'h000, bank_active}, 16'h000C, "banks 2 3");
    wr(2'h2, 9'h000, 1, 1'b0);
    repeat (2) ctl.issue(1'b1, 3'h7, 2'h0, 12'h000, 2'h0, 16'h0000, 1'b0,
      1'b0);
    compare({10'h000, power_mode}, {10'h000, ST_SUSPEND}, "suspend");
    nop(1);
    op(CMD_BST, 2'h0, 12'h000);
    op(CMD_PRE, 2'h0, 12'h400);
    nop(3);
    compare({12'h000, bank_active}, 16'h0000, "all banks");
    compare(16'(notes.size()), 16'h0000, "reads never returned");
    wrap_up();
  end
endmodule
